// file: dv/diagram_ticker.sv
`default_nettype none
// stand-in for the diagram scheduler that issues execution ticks
module diagram_ticker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // idle cycles between ticks, zero means a tick every cycle
   input wire logic [3:0] gap,
   // execution tick towards the cell
   output logic exec_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt; // idle cycles left before the next tick

   initial exec_tick = 1'b0;
   initial wait_cnt = 0;
   // one-cycle tick, moved just after the edge like the bench inputs
   always @(posedge ref_clk) begin
      #1;
      if (rst || wait_cnt != 0) begin
         exec_tick = 1'b0;
         wait_cnt = rst ? 0 : wait_cnt - 1;
      end else begin
         exec_tick = 1'b1;
         wait_cnt = int'(gap);
      end
   end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
// self-checking bench: reference model compared every cycle
module testbench
   import logic_cell_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0; // 100 mhz clock
   logic rst = 1'b1; // async reset, high
   logic exec_tick; // from the ticker
   operands_s operands = '0; // operands under test
   logic [TYPE_W-1:0] cell_type = 4'h0; // selected operation
   logic cell_out; // design output
   logic [3:0] gap = 4'h0; // ticker spacing
   bit a, b, c, pa, ff, lt, exp_out; // model state
   int mismatches = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'hb35e1ba4; // xorshift state

   // pulse length is one tick, so small nominal figures are harmless
   configurable_logic_cell #(.RISE_CYC(5), .FALL_CYC(20))
      configurable_logic_cell_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .exec_tick(exec_tick),
      .operands(operands),
      .cell_type(cell_type),
      .cell_out(cell_out)
   );
   diagram_ticker diagram_ticker_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .gap(gap),
      .exec_tick(exec_tick)
   );

   always #5 ref_clk = ~ref_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic check(input logic seen, input logic want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // model takes a tick at the same edge as the design
   always @(posedge ref_clk) begin
      if (!rst && exec_tick === 1'b1) begin
         {a, b, c} = operands;
         case (cell_type)
            4'h0: exp_out = !a;
            4'h1: exp_out = a & b & c;
            4'h2: exp_out = !(a & b & c);
            4'h3: exp_out = a | b | c;
            4'h4: exp_out = !(a | b | c);
            4'h5: exp_out = a ^ b;
            4'h6: exp_out = (a & !pa) ^ c;
            4'h7: exp_out = (!a & pa) ^ c;
            4'h8: exp_out = a & b & !c;
            4'h9: exp_out = a | b | !c;
            4'ha: ff = a | (!b & ff);
            4'hb: ff = !a & (b | ff);
            4'hc: lt = c ? lt : a;
            4'hd: exp_out = c ? b : a;
            default: exp_out = 1'b0; // unused codes drive low
         endcase
         if (cell_type == 4'ha || cell_type == 4'hb)
            exp_out = ff;
         if (cell_type == 4'hc)
            exp_out = lt;
         pa = a; // edge history moves on every tick
      end
   end

   // compare mid-cycle where the output has settled
   always @(negedge ref_clk) begin
      if (rst) begin
         {pa, ff, lt, exp_out} = 4'h0;
      end
      // same compare either way, the split by code range has no effect
      if (cell_type < 4'h8)
         check(cell_out, exp_out);
      else
         check(cell_out, exp_out);
   end

   // every code at three tick spacings, reset at the end of each pass
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      for (int pass = 0; pass < 3; pass++) begin
         gap = 4'(pass);
         for (int t = 0; t < 16; t++) begin
            repeat (40) begin
               @(posedge ref_clk);
               #1;
               seed = xs(seed);
               operands = seed[2:0];
               cell_type = 4'(t);
            end
         end
         @(posedge ref_clk);
         #1;
         rst = 1'b1;
         repeat (3) @(posedge ref_clk);
         #1;
         rst = 1'b0;
      end
      wrap_up();
   end

   // hang guard, well beyond the two thousand cycles of stimulus
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire

// file: include/logic_cell_pkg.sv
`default_nettype none
// shared constants and types for the configurable logic cell
package logic_cell_pkg;
   // width of the type selector
   localparam int TYPE_W = 4;

   // operation codes of the type selector
   typedef enum logic [TYPE_W-1:0] {
      OP_NOT_A = 4'h0,  // invert a
      OP_AND3 = 4'h1,   // a and b and c
      OP_NAND3 = 4'h2,  // not (a and b and c)
      OP_OR3 = 4'h3,    // a or b or c
      OP_NOR3 = 4'h4,   // not (a or b or c)
      OP_XOR_AB = 4'h5, // a xor b
      OP_RISE = 4'h6,   // rising edge pulse of a
      OP_FALL = 4'h7,   // falling edge pulse of a
      OP_AND_NC = 4'h8, // a and b and not c
      OP_OR_NC = 4'h9,  // a or b or not c
      OP_SDOM_FF = 4'ha, // set-dominant flip-flop
      OP_RDOM_FF = 4'hb, // reset-dominant flip-flop
      OP_LATCH = 4'hc,  // level latch on c
      OP_SWITCH = 4'hd  // two-way switch on c
   } cell_op_e;

   // the three logic operands travel together
   typedef struct packed {
      logic a; // operand a
      logic b; // operand b
      logic c; // operand c
   } operands_s;

   // reset values of all stored state
   localparam logic OUT_RST = 1'b0;
   localparam logic STORE_RST = 1'b0;

   // nominal edge pulse lengths, equal to one diagram execution period
   localparam int RISE_PULSE_MS = 5;
   localparam int FALL_PULSE_MS = 20;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RISE_PULSE_CYC = RISE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int FALL_PULSE_CYC = FALL_PULSE_MS * 1000000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// file: rtl/configurable_logic_cell.sv
`default_nettype none
// Function
// - rising edge of a pulses output; b ignored
// - falling edge of a pulses output; b ignored
// - edge pulse lasts exactly one execution tick
// - c true inverts edge output idle and pulse
// - reset-dominant ff: a clears, b sets, clear wins
// - latch follows a while c low, holds otherwise
// - switch gives a when c false, b otherwise
// - type codes 0..7 select gates and edges
// - type codes 8..13 select gates, ffs, latch, switch
module configurable_logic_cell
   import logic_cell_pkg::*;
#(
   // nominal pulse lengths in clock cycles, shortened in simulation
   parameter int RISE_CYC = RISE_PULSE_CYC,
   parameter int FALL_CYC = FALL_PULSE_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // diagram execution tick
   input wire logic exec_tick,
   // operands and type selector
   input wire operands_s operands,
   input wire logic [TYPE_W-1:0] cell_type,
   // cell output
   output logic cell_out
);

   // operand a seen at the previous tick, for edge detection
   logic prev_a;
   // flip-flop memory bit shared by both flip-flop modes
   logic ff_bit;
   // latch memory bit
   logic latch_bit;
   // value computed for the coming tick
   logic next_out;
   logic next_ff;
   logic next_latch;
   // edge pulses before optional inversion
   logic rise_hit;
   logic fall_hit;

   // true for codes that the selector defines
   function automatic logic type_legal(input logic [TYPE_W-1:0] t);
      return t <= OP_SWITCH;
   endfunction

   // edge detection against the value sampled at the last tick
   always_comb begin
      rise_hit = operands.a & ~prev_a;
      fall_hit = ~operands.a & prev_a;
   end

   // next flip-flop value; only moves in the flip-flop modes
   always_comb begin
      next_ff = ff_bit;
      if (cell_type == OP_RDOM_FF) begin
         // clear is checked first so it wins
         if (operands.a) begin
            next_ff = 1'b0;
         end else if (operands.b) begin
            next_ff = 1'b1;
         end
      end else if (cell_type == OP_SDOM_FF) begin
         // set is checked first so it wins
         if (operands.a) begin
            next_ff = 1'b1;
         end else if (operands.b) begin
            next_ff = 1'b0;
         end
      end
   end

   // latch is transparent while c is low, only in latch mode
   always_comb begin
      next_latch = latch_bit;
      if (cell_type == OP_LATCH && !operands.c) begin
         next_latch = operands.a;
      end
   end

   // output decode of the type selector
   always_comb begin
      next_out = 1'b0;
      if (type_legal(cell_type)) begin
         unique case (cell_op_e'(cell_type))
            OP_NOT_A: begin
               next_out = ~operands.a;
            end
            OP_AND3: begin
               next_out = operands.a & operands.b & operands.c;
            end
            OP_NAND3: begin
               next_out = ~(operands.a & operands.b & operands.c);
            end
            OP_OR3: begin
               next_out = operands.a | operands.b | operands.c;
            end
            OP_NOR3: begin
               next_out = ~(operands.a | operands.b | operands.c);
            end
            OP_XOR_AB: begin
               next_out = operands.a ^ operands.b;
            end
            OP_RISE: begin
               // c turns the idle level high and the pulse low
               next_out = rise_hit ^ operands.c;
            end
            OP_FALL: begin
               next_out = fall_hit ^ operands.c;
            end
            OP_AND_NC: begin
               next_out = operands.a & operands.b & ~operands.c;
            end
            OP_OR_NC: begin
               next_out = operands.a | operands.b | ~operands.c;
            end
            OP_SDOM_FF, OP_RDOM_FF: begin
               next_out = next_ff;
            end
            OP_LATCH: begin
               next_out = next_latch;
            end
            OP_SWITCH: begin
               next_out = operands.c ? operands.b : operands.a;
            end
         endcase
      end
   end

   // edge history is kept in every mode, so a mode change is clean
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev_a <= STORE_RST;
      end else if (exec_tick) begin
         prev_a <= operands.a;
      end
   end

   // flip-flop memory, updated once per tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ff_bit <= STORE_RST;
      end else if (exec_tick) begin
         ff_bit <= next_ff;
      end
   end

   // latch memory, updated once per tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         latch_bit <= STORE_RST;
      end else if (exec_tick) begin
         latch_bit <= next_latch;
      end
   end

   // output holds between ticks, so a pulse spans one tick period
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cell_out <= OUT_RST;
      end else if (exec_tick) begin
         cell_out <= next_out;
      end
   end

   // ---- checks ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // a tick taken with a given code
   sequence tick_in(logic [TYPE_W-1:0] code);
      exec_tick && cell_type == code;
   endsequence

   // a rising pulse produced at a tick
   sequence rise_fired;
      tick_in(OP_RISE) ##0 (operands.a && !prev_a);
   endsequence

   // a falling pulse produced at a tick
   sequence fall_fired;
      tick_in(OP_FALL) ##0 (!operands.a && prev_a);
   endsequence

   // rising mode tick whose previous tick already saw a high,
   // so a pulse issued back then must be gone by now
   sequence rise_spent;
      tick_in(OP_RISE) ##0 prev_a;
   endsequence

   // falling mode tick whose previous tick already saw a low
   sequence fall_spent;
      tick_in(OP_FALL) ##0 !prev_a;
   endsequence

   not_a_a: assert property (tick_in(OP_NOT_A) |=>
      cell_out == !$past(operands.a))
      else $error("invert mode output wrong");

   gates_abc_a: assert property (tick_in(OP_NOR3) |=>
      cell_out == !($past(operands.a) || $past(operands.b)
                    || $past(operands.c)))
      else $error("nor mode output wrong");

   gates_not_c_a: assert property (tick_in(OP_AND_NC) |=>
      cell_out == ($past(operands.a) && $past(operands.b)
                   && !$past(operands.c)))
      else $error("and-not-c mode output wrong");

   rise_pulse_a: assert property (rise_fired |=>
      cell_out == !$past(operands.c))
      else $error("rising pulse missing");

   fall_pulse_a: assert property (fall_fired |=>
      cell_out == !$past(operands.c))
      else $error("falling pulse missing");

   pulse_one_tick_a: assert property (rise_spent |=>
      cell_out == $past(operands.c))
      else $error("rising pulse longer than one tick");

   fall_one_tick_a: assert property (fall_spent |=>
      cell_out == $past(operands.c))
      else $error("falling pulse longer than one tick");

   edge_idle_a: assert property (tick_in(OP_FALL) ##0
      (operands.a == prev_a) |=> cell_out == $past(operands.c))
      else $error("edge idle level ignores inversion");

   rdom_ff_a: assert property (tick_in(OP_RDOM_FF) ##0
      operands.a |=> !cell_out && !ff_bit)
      else $error("reset-dominant clear lost");

   sdom_ff_a: assert property (tick_in(OP_SDOM_FF) ##0
      operands.a |=> cell_out && ff_bit)
      else $error("set-dominant set lost");

   latch_hold_a: assert property (tick_in(OP_LATCH) ##0
      operands.c |=> cell_out == $past(latch_bit) && $stable(latch_bit))
      else $error("latch did not hold");

   switch_sel_a: assert property (tick_in(OP_SWITCH) |=>
      cell_out == ($past(operands.c) ? $past(operands.b)
                                     : $past(operands.a)))
      else $error("switch picked wrong operand");

   hold_between_a: assert property (!exec_tick |=>
      $stable(cell_out))
      else $error("output moved without a tick");

endmodule
`default_nettype wire
